//--- design/gms_pkg.sv
// Constants and types shared by the gauge measurement sequencer.
// Assumes a 20 MHz system clock and a 32768 Hz converter time base clock.
package gms_pkg;

    // Converter time base and conversion durations in their own units.
    localparam int unsigned TB_HZ         = 32768;
    localparam int unsigned VT_CONV_MS    = 250;
    localparam int unsigned CUR_CONV_MS   = 500;
    localparam int unsigned MEAS_PERIOD_S = 4;
    localparam int unsigned TEMP_PERIOD_S = 16;

    // Cycle counts of the time base derived from the durations above.
    localparam int unsigned VT_CYCLES     = TB_HZ * VT_CONV_MS / 1000;
    localparam int unsigned CUR_CYCLES    = TB_HZ * CUR_CONV_MS / 1000;
    localparam int unsigned PERIOD_CYCLES = TB_HZ * MEAS_PERIOD_S;
    localparam int unsigned TEMP_EVERY    = TEMP_PERIOD_S / MEAS_PERIOD_S;
    localparam int unsigned CNT_W         = 18;

    // Widths of results and registers.
    localparam int unsigned ADC_W  = 14;
    localparam int unsigned VOLT_W = 12;
    localparam int unsigned TEMP_W = 8;
    localparam int unsigned TAB_N  = 16;

    // Values after reset.
    localparam logic [15:0] CC_CFG_RST   = 16'h018b;
    localparam logic [11:0] VM_CFG_RST   = 12'h141;
    localparam logic        MODE_SEL_RST = 1'h1;

    // Bit positions in the mode control register.
    localparam int unsigned MODE_SEL_BIT = 0;
    localparam int unsigned CLR_CC_BIT   = 1;
    localparam int unsigned CLR_VM_BIT   = 2;

    // Register byte addresses; multi-byte values are low byte first.
    localparam logic [7:0] ADDR_MODE     = 8'h00;
    localparam logic [7:0] ADDR_SOC      = 8'h02;
    localparam logic [7:0] ADDR_CHARGE   = 8'h04;
    localparam logic [7:0] ADDR_COUNT    = 8'h08;
    localparam logic [7:0] ADDR_CURRENT  = 8'h0a;
    localparam logic [7:0] ADDR_VOLTAGE  = 8'h0c;
    localparam logic [7:0] ADDR_TEMP     = 8'h0e;
    localparam logic [7:0] ADDR_CC_CFG   = 8'h10;
    localparam logic [7:0] ADDR_VM_CFG   = 8'h12;
    localparam logic [7:0] ADDR_REST_V  = 8'h14;
    localparam logic [7:0] ADDR_CC_ADJ   = 8'h16;
    localparam logic [7:0] ADDR_VM_ADJ   = 8'h18;
    localparam logic [7:0] ADDR_CC_ACC   = 8'h1a;
    localparam logic [7:0] ADDR_VM_ACC   = 8'h1c;
    localparam logic [3:0] TAB_PAGE      = 4'h3;

    // Converter input selection.
    typedef enum logic [1:0] {
        conv_idle = 2'h0,
        conv_cur  = 2'h1,
        conv_volt = 2'h2,
        conv_temp = 2'h3
    } gms_conv_e;

endpackage

//--- design/gms_top.sv
// Measurement sequencer and gauge bookkeeping of the fuel gauge.
// Assumes a decoded byte register port from the serial slave on clk_in,
// and a converter that delivers a result on tb_clk_in at each conversion end.

// How it works
// - Mode bit 0 selects mixed operation, 1 selects voltage-only operation.
// - Mixed: current runs back to back while a whole one fits the period, voltage every 4 s, temperature every 16 s.
// - Voltage-only: no current conversions, voltage every 4 s, temperature every 16 s.
// - Each voltage or temperature conversion lasts 8192 time base cycles.
// - Voltage result, 2.20 mV per count, goes to the voltage register.
// - Temperature result, 1 degree per count, goes to the temperature register.
// - Current conversion lasts 500 ms giving a 14-bit signed result.
// - Each current result is added to the charge sum while the mode bit is 0; conversion count increments.
// - Current register takes only the conversion nearest the voltage conversion.
// - Charge scaling register resets to 395; the host reads and writes it.
// - Charge counting stops while the mode bit is 1; bit resets to 1.
// - Writing the state-of-charge register restarts charge tracking from it.
// - Voltage model register resets to 321; the host reads and writes its 12 bits.
// - Estimated rest voltage is kept current; host may edit the rest voltage table.
// - Adjustment registers follow the estimator continuously as signed 16-bit values.
// - Adjustment accumulators update only when the estimation method switches.
// - Host clear bits zero the matching adjustment accumulator.
// - Power-saving operation stops charge counting, voltage gauge keeps running.
// - Mixed operation picks the method itself from the estimator's choice.
// - Host reaches all registers and the charge sum through the serial slave.
module gms_top #(
    parameter int unsigned VT_CYCLES_P     = gms_pkg::VT_CYCLES,
    parameter int unsigned CUR_CYCLES_P    = gms_pkg::CUR_CYCLES,
    parameter int unsigned PERIOD_CYCLES_P = gms_pkg::PERIOD_CYCLES
) (
    // Clocks and reset.
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        tb_clk_in,
    // Register port from the serial slave.
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        wr_en_in,
    input  wire logic [7:0]  wr_data_in,
    output logic      [7:0]  rd_data_out,
    // Converter side, time base domain.
    input  wire logic [13:0] adc_data_in,
    output logic      [1:0]  conv_sel_out,
    // Gauge estimator side.
    input  wire logic        method_cc_in,
    input  wire logic [15:0] cc_adj_in,
    input  wire logic [15:0] vm_adj_in,
    input  wire logic [15:0] rest_volt_in,
    input  wire logic [3:0]  tab_idx_in,
    output logic      [7:0]  tab_data_out,
    output logic             method_cc_out,
    output logic             mode_sel_out,
    output logic             soc_restart_out
);

    localparam int unsigned CW = gms_pkg::CNT_W;

    // State of the time base domain.
    typedef struct packed {
        logic                 rst_s1;
        logic                 rst_s2;
        logic                 mode_s1;
        logic                 mode_s2;
        logic                 mode_l;
        logic                 temp_due;
        logic [1:0]           cyc_idx;
        logic [CW-1:0]        per_cnt;
        logic [CW-1:0]        conv_cnt;
        gms_pkg::gms_conv_e   sel;
        logic                 tog;
        gms_pkg::gms_conv_e   kind;
        logic                 near;
        logic [13:0]          res;
    } gms_tb_s;

    // State of the system clock domain.
    typedef struct packed {
        logic                 tg_s1;
        logic                 tg_s2;
        logic                 tg_s3;
        logic                 mode_sel;
        logic [15:0]          soc;
        logic                 soc_rst;
        logic [31:0]          charge;
        logic [15:0]          count;
        logic [13:0]          cur_res;
        logic [11:0]          volt_res;
        logic [7:0]           temp_res;
        logic [15:0]          cc_cfg;
        logic [11:0]          vm_cfg;
        logic [15:0]          rest_v;
        logic [15:0]          cc_adj;
        logic [15:0]          vm_adj;
        logic [15:0]          cc_acc;
        logic [15:0]          vm_acc;
        logic                 method;
        logic [15:0][7:0]     tab;
        logic [7:0]           tab_out;
        logic [7:0]           rd;
    } gms_sys_s;

    gms_tb_s  q_t;
    gms_tb_s  d_t;
    gms_sys_s q;
    gms_sys_s d;

    logic          can_cur;
    logic          conv_end;
    logic [CW-1:0] conv_len;
    logic          evt;
    logic          eff_cc;
    logic          sw;
    logic          wr_mode;

    // Time base side: schedules conversions within each 4 s period.
    always_comb begin
        d_t         = q_t;
        d_t.rst_s1  = rstn_in;
        d_t.rst_s2  = q_t.rst_s1;
        d_t.mode_s1 = q.mode_sel;
        d_t.mode_s2 = q_t.mode_s1;
        conv_len = (q_t.sel == gms_pkg::conv_cur) ? CW'(CUR_CYCLES_P - 1) : CW'(VT_CYCLES_P - 1);
        conv_end = (q_t.sel != gms_pkg::conv_idle) && (q_t.conv_cnt == conv_len);
        can_cur  = (CW'(PERIOD_CYCLES_P - 1) - q_t.per_cnt) >= CW'(CUR_CYCLES_P);
        if (!q_t.rst_s2) begin
            d_t.mode_l   = gms_pkg::MODE_SEL_RST;
            d_t.temp_due = 1'h0;
            d_t.cyc_idx  = 2'h0;
            d_t.per_cnt  = '0;
            d_t.conv_cnt = '0;
            d_t.sel      = gms_pkg::conv_idle;
            d_t.tog      = 1'h0;
            d_t.kind     = gms_pkg::conv_idle;
            d_t.near     = 1'h0;
            d_t.res      = 14'h0000;
        end else begin
            if (q_t.per_cnt == CW'(PERIOD_CYCLES_P - 1)) begin
                d_t.per_cnt = '0;
            end else begin
                d_t.per_cnt = q_t.per_cnt + CW'(1);
            end
            if (q_t.per_cnt == '0) begin
                // Period start: mode is sampled only here so no conversion is cut.
                d_t.mode_l   = q_t.mode_s2;
                d_t.sel      = gms_pkg::conv_volt;
                d_t.conv_cnt = '0;
                d_t.temp_due = (q_t.cyc_idx == 2'h0);
                d_t.cyc_idx  = (q_t.cyc_idx == 2'(gms_pkg::TEMP_EVERY - 1)) ? 2'h0
                               : q_t.cyc_idx + 2'h1;
            end else if (conv_end) begin
                // Hand the finished result over with a toggle; data holds for the next one.
                d_t.res      = adc_data_in;
                d_t.kind     = q_t.sel;
                d_t.near     = (q_t.sel == gms_pkg::conv_cur) && !can_cur;
                d_t.tog      = !q_t.tog;
                d_t.conv_cnt = '0;
                if (q_t.sel == gms_pkg::conv_volt && q_t.temp_due) begin
                    d_t.sel = gms_pkg::conv_temp;
                end else if (!q_t.mode_l && can_cur) begin
                    d_t.sel = gms_pkg::conv_cur;
                end else begin
                    d_t.sel = gms_pkg::conv_idle;
                end
            end else if (q_t.sel != gms_pkg::conv_idle) begin
                d_t.conv_cnt = q_t.conv_cnt + CW'(1);
            end
        end
    end

    // Time base registers.
    always_ff @(posedge tb_clk_in) begin
        q_t <= d_t;
    end

    // System side helper terms: result arrival, method switch, mode write.
    assign evt     = q.tg_s2 ^ q.tg_s3;
    assign eff_cc  = !q.mode_sel && method_cc_in;
    assign sw      = eff_cc != q.method;
    assign wr_mode = wr_en_in && (reg_addr_in == gms_pkg::ADDR_MODE);

    // System side: results, charge counting, registers and read answer.
    always_comb begin
        d         = q;
        d.tg_s1   = q_t.tog;
        d.tg_s2   = q.tg_s1;
        d.tg_s3   = q.tg_s2;
        d.soc_rst = 1'h0;
        d.method  = eff_cc;
        d.rest_v  = rest_volt_in;
        d.cc_adj  = cc_adj_in;
        d.vm_adj  = vm_adj_in;
        d.tab_out = q.tab[tab_idx_in];
        if (evt) begin
            if (q_t.kind == gms_pkg::conv_cur) begin
                if (!q.mode_sel) begin
                    d.charge = q.charge + {{18{q_t.res[13]}}, q_t.res};
                    d.count  = q.count + 16'h0001;
                end
                if (q_t.near) begin
                    d.cur_res = q_t.res;
                end
            end else if (q_t.kind == gms_pkg::conv_volt) begin
                d.volt_res = q_t.res[11:0];
            end else if (q_t.kind == gms_pkg::conv_temp) begin
                d.temp_res = q_t.res[7:0];
            end
        end
        if (sw) begin
            d.cc_acc = q.cc_acc + q.cc_adj;
            d.vm_acc = q.vm_acc + q.vm_adj;
        end
        // Register writes from the host; clears win over a same-cycle switch.
        if (wr_en_in) begin
            if (reg_addr_in == gms_pkg::ADDR_MODE) begin
                d.mode_sel = wr_data_in[gms_pkg::MODE_SEL_BIT];
                if (wr_data_in[gms_pkg::CLR_CC_BIT]) begin
                    d.cc_acc = 16'h0000;
                end
                if (wr_data_in[gms_pkg::CLR_VM_BIT]) begin
                    d.vm_acc = 16'h0000;
                end
            end else if (reg_addr_in[7:1] == gms_pkg::ADDR_SOC[7:1]) begin
                d.soc[8*reg_addr_in[0] +: 8] = wr_data_in;
                d.soc_rst                    = 1'h1;
            end else if (reg_addr_in[7:1] == gms_pkg::ADDR_CC_CFG[7:1]) begin
                d.cc_cfg[8*reg_addr_in[0] +: 8] = wr_data_in;
            end else if (reg_addr_in == gms_pkg::ADDR_VM_CFG) begin
                d.vm_cfg[7:0] = wr_data_in;
            end else if (reg_addr_in == gms_pkg::ADDR_VM_CFG + 8'h01) begin
                d.vm_cfg[11:8] = wr_data_in[3:0];
            end else if (reg_addr_in[7:4] == gms_pkg::TAB_PAGE) begin
                d.tab[reg_addr_in[3:0]] = wr_data_in;
            end
        end
        // Read answer for the presented address; unmapped reads as zero.
        if (reg_addr_in == gms_pkg::ADDR_MODE) begin
            d.rd = {7'h00, q.mode_sel};
        end else if (reg_addr_in[7:1] == gms_pkg::ADDR_SOC[7:1]) begin
            d.rd = q.soc[8*reg_addr_in[0] +: 8];
        end else if (reg_addr_in[7:2] == gms_pkg::ADDR_CHARGE[7:2]) begin
            d.rd = q.charge[8*reg_addr_in[1:0] +: 8];
        end else if (reg_addr_in[7:1] == gms_pkg::ADDR_COUNT[7:1]) begin
            d.rd = q.count[8*reg_addr_in[0] +: 8];
        end else if (reg_addr_in == gms_pkg::ADDR_CURRENT) begin
            d.rd = q.cur_res[7:0];
        end else if (reg_addr_in == gms_pkg::ADDR_CURRENT + 8'h01) begin
            d.rd = {{2{q.cur_res[13]}}, q.cur_res[13:8]};
        end else if (reg_addr_in == gms_pkg::ADDR_VOLTAGE) begin
            d.rd = q.volt_res[7:0];
        end else if (reg_addr_in == gms_pkg::ADDR_VOLTAGE + 8'h01) begin
            d.rd = {4'h0, q.volt_res[11:8]};
        end else if (reg_addr_in == gms_pkg::ADDR_TEMP) begin
            d.rd = q.temp_res;
        end else if (reg_addr_in[7:1] == gms_pkg::ADDR_CC_CFG[7:1]) begin
            d.rd = q.cc_cfg[8*reg_addr_in[0] +: 8];
        end else if (reg_addr_in == gms_pkg::ADDR_VM_CFG) begin
            d.rd = q.vm_cfg[7:0];
        end else if (reg_addr_in == gms_pkg::ADDR_VM_CFG + 8'h01) begin
            d.rd = {4'h0, q.vm_cfg[11:8]};
        end else if (reg_addr_in[7:1] == gms_pkg::ADDR_REST_V[7:1]) begin
            d.rd = q.rest_v[8*reg_addr_in[0] +: 8];
        end else if (reg_addr_in[7:1] == gms_pkg::ADDR_CC_ADJ[7:1]) begin
            d.rd = q.cc_adj[8*reg_addr_in[0] +: 8];
        end else if (reg_addr_in[7:1] == gms_pkg::ADDR_VM_ADJ[7:1]) begin
            d.rd = q.vm_adj[8*reg_addr_in[0] +: 8];
        end else if (reg_addr_in[7:1] == gms_pkg::ADDR_CC_ACC[7:1]) begin
            d.rd = q.cc_acc[8*reg_addr_in[0] +: 8];
        end else if (reg_addr_in[7:1] == gms_pkg::ADDR_VM_ACC[7:1]) begin
            d.rd = q.vm_acc[8*reg_addr_in[0] +: 8];
        end else if (reg_addr_in[7:4] == gms_pkg::TAB_PAGE) begin
            d.rd = q.tab[reg_addr_in[3:0]];
        end else begin
            d.rd = 8'h00;
        end
        // Synchronous reset; the toggle synchroniser keeps running through it.
        if (!rstn_in) begin
            d          = '0;
            d.tg_s1    = q_t.tog;
            d.tg_s2    = q.tg_s1;
            d.tg_s3    = q.tg_s2;
            d.mode_sel = gms_pkg::MODE_SEL_RST;
            d.cc_cfg   = gms_pkg::CC_CFG_RST;
            d.vm_cfg   = gms_pkg::VM_CFG_RST;
        end
    end

    // System clock registers.
    always_ff @(posedge clk_in) begin
        q <= d;
    end

    // Outputs come straight from flip-flops.
    assign rd_data_out     = q.rd;
    assign conv_sel_out    = q_t.sel;
    assign tab_data_out    = q.tab_out;
    assign method_cc_out   = q.method;
    assign mode_sel_out    = q.mode_sel;
    assign soc_restart_out = q.soc_rst;

    // Mode bit and configuration registers hold their reset values.
    property p_mode_rst;
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(rstn_in) |-> q.mode_sel && q.cc_cfg == 16'h018b && q.vm_cfg == 12'h141;
    endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("reset values wrong");

    // A current result bumps the conversion count in mixed mode when no host write is under way.
    property p_count;
        @(posedge clk_in) disable iff (!rstn_in)
        (evt && q_t.kind == gms_pkg::conv_cur && !q.mode_sel && !wr_en_in)
        |=> q.count == $past(q.count) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("conversion count not incremented");
    // No charge counting in voltage-only mode.
    property p_no_count;
        @(posedge clk_in) disable iff (!rstn_in)
        (q.mode_sel && !wr_mode) |=> $stable(q.charge) && $stable(q.count);
    endproperty
    a_no_count: assert property (p_no_count) else $error("charge counted in voltage mode");
    // The current register only changes on the result nearest the voltage conversion.
    property p_cur_near;
        @(posedge clk_in) disable iff (!rstn_in)
        $changed(q.cur_res) |-> $past(evt && q_t.near && q_t.kind == gms_pkg::conv_cur);
    endproperty
    a_cur_near: assert property (p_cur_near) else $error("current register updated early");

    // A CC clear bit write leaves the CC adjustment accumulator at zero.
    property p_clear;
        @(posedge clk_in) disable iff (!rstn_in)
        (wr_mode && wr_data_in[gms_pkg::CLR_CC_BIT]) |=> q.cc_acc == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("accumulator not cleared");
    // The VM accumulator moves only on a method switch or a mode register write.
    property p_acc_switch;
        @(posedge clk_in) disable iff (!rstn_in)
        $changed(q.vm_acc) |-> $past(sw || wr_mode);
    endproperty
    a_acc_switch: assert property (p_acc_switch) else $error("accumulator moved without switch");

    // Writing the state of charge raises the restart pulse for one cycle.
    property p_soc_restart;
        @(posedge clk_in) disable iff (!rstn_in)
        (wr_en_in && reg_addr_in == gms_pkg::ADDR_SOC) |=> soc_restart_out ##1 !soc_restart_out;
    endproperty
    a_soc_restart: assert property (p_soc_restart) else $error("no tracking restart");
    // Voltage-only periods hold no current conversion.
    property p_no_cur;
        @(posedge tb_clk_in) disable iff (!q_t.rst_s2)
        (q_t.mode_l && q_t.per_cnt != '0) |-> q_t.sel != gms_pkg::conv_cur;
    endproperty
    a_no_cur: assert property (p_no_cur) else $error("current conversion in voltage mode");

    // A voltage conversion runs to its full length before anything else.
    property p_vt_len;
        @(posedge tb_clk_in) disable iff (!q_t.rst_s2)
        (q_t.sel == gms_pkg::conv_volt && q_t.conv_cnt != CW'(VT_CYCLES_P - 1))
        |=> q_t.sel == gms_pkg::conv_volt && q_t.conv_cnt == $past(q_t.conv_cnt) + CW'(1);
    endproperty
    a_vt_len: assert property (p_vt_len) else $error("voltage conversion cut short");

    // Each period opens with a voltage conversion.
    property p_period;
        @(posedge tb_clk_in) disable iff (!q_t.rst_s2)
        (q_t.per_cnt == '0) |=> q_t.sel == gms_pkg::conv_volt && q_t.conv_cnt == '0;
    endproperty
    a_period: assert property (p_period) else $error("period did not start with voltage");

endmodule

//--- sim/gms_conv_model.sv
// Converter model answering each conversion kind on the time base clock.
// Assumes conv_sel_in is the sequencer's time base flop.
module gms_conv_model (
    // Time base clock.
    input  wire logic        tb_clk_in,
    // Selection from the sequencer.
    input  wire logic [1:0]  conv_sel_in,
    // Result and current cycle tally.
    output logic      [13:0] adc_data_out,
    output logic      [15:0] cur_cycles_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] idle_q = 14'h1555;
    initial cur_cycles_out = 16'h0;
    // Idle pattern flips each cycle so a stale result is never mistaken for a fresh one.
    always @(posedge tb_clk_in) begin
        idle_q <= ~idle_q;
        if (conv_sel_in == 2'h1) begin
            cur_cycles_out <= cur_cycles_out + 16'h1;
        end
    end
    // Negative current, and junk above the voltage and temperature fields.
    always_comb begin
        case (conv_sel_in)
            2'h1: adc_data_out = 14'h3ffd;
            2'h2: adc_data_out = 14'h2abc;
            2'h3: adc_data_out = 14'h3f19;
            default: adc_data_out = idle_q;
        endcase
    end
endmodule

//--- sim/gms_top_test.sv
// Self-checking bench of the measurement sequencer with shortened counts.
// Assumes the converter model and the design package are compiled first.
module gms_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 1'b0;
    logic        tb_clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic        wr_en_in = 1'b0;
    logic [7:0]  wr_data_in = 8'h00;
    logic        method_cc_in = 1'b0;
    logic [15:0] cc_adj_in = 16'h1234;
    logic [15:0] vm_adj_in = 16'h0567;
    logic [15:0] rest_volt_in = 16'h0e42;
    logic [3:0]  tab_idx_in = 4'h3;
    logic [7:0]  rd_data_out;
    logic [7:0]  tab_data_out;
    logic [13:0] adc_data_in;
    logic [1:0]  conv_sel_out;
    logic        method_cc_out;
    logic        mode_sel_out;
    logic        soc_restart_out;
    logic [15:0] cur_cyc;
    int          miscompares = 0;
    int          checks_done = 0;

    // System clock, and a time base clock of unrelated phase.
    always #25 clk_in = ~clk_in;
    initial begin
        #7;
        forever #32 tb_clk_in = ~tb_clk_in;
    end

    // Design and converter model.
    gms_top #(.VT_CYCLES_P(8), .CUR_CYCLES_P(16), .PERIOD_CYCLES_P(128)) dut_u (
        .clk_in(clk_in), .rstn_in(rstn_in), .tb_clk_in(tb_clk_in),
        .reg_addr_in(reg_addr_in), .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
        .rd_data_out(rd_data_out), .adc_data_in(adc_data_in), .conv_sel_out(conv_sel_out),
        .method_cc_in(method_cc_in), .cc_adj_in(cc_adj_in), .vm_adj_in(vm_adj_in),
        .rest_volt_in(rest_volt_in), .tab_idx_in(tab_idx_in), .tab_data_out(tab_data_out),
        .method_cc_out(method_cc_out), .mode_sel_out(mode_sel_out),
        .soc_restart_out(soc_restart_out));
    gms_conv_model model_u (.tb_clk_in(tb_clk_in), .conv_sel_in(conv_sel_out),
        .adc_data_out(adc_data_in), .cur_cycles_out(cur_cyc));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask
    // Reads n bytes from a upward, low byte first.
    task automatic rdn(input logic [7:0] a, input int n, output logic [31:0] v);
        v = 32'h0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            reg_addr_in <= a + 8'(i);
            repeat (2) @(posedge clk_in);
            #1 v[8*i+:8] = rd_data_out;
        end
    endtask
    // Waits for the next voltage conversion start, then a few cycles for results to land.
    task automatic wait_volt;
        int n = 0;
        while (conv_sel_out === 2'h2 && n < 400) begin
            @(posedge clk_in);
            n++;
        end
        while (conv_sel_out !== 2'h2 && n < 400) begin
            @(posedge clk_in);
            n++;
        end
        chk(n < 400, 1'b1);
        repeat (8) @(posedge clk_in);
    endtask

    task automatic t_reset;
        logic [31:0] v;
        rdn(gms_pkg::ADDR_CC_CFG, 2, v);
        chk(v, 32'h018b);
        rdn(gms_pkg::ADDR_VM_CFG, 2, v);
        chk(v, 32'h0141);
        rdn(gms_pkg::ADDR_MODE, 1, v);
        chk(v, 32'h01);
        chk(mode_sel_out, 1'b1);
        rdn(8'h40, 1, v);
        chk(v, 32'h0);
        wr(gms_pkg::ADDR_CC_CFG, 8'h22);
        rdn(gms_pkg::ADDR_CC_CFG, 2, v);
        chk(v, 32'h0122);
    endtask
    task automatic t_volt_only;
        logic [31:0] v;
        wait_volt;
        wait_volt;
        rdn(gms_pkg::ADDR_VOLTAGE, 2, v);
        chk(v, 32'h0abc);
        rdn(gms_pkg::ADDR_TEMP, 1, v);
        chk(v, 32'h19);
        rdn(gms_pkg::ADDR_COUNT, 2, v);
        chk(v, 32'h0);
        chk(cur_cyc, 16'h0);
    endtask
    task automatic t_mixed;
        logic [31:0] v;
        int n;
        wr(gms_pkg::ADDR_MODE, 8'h00);
        wait_volt;
        chk(cur_cyc, 16'h0);
        wait_volt;
        n = int'(cur_cyc) / 16;
        chk(n != 0, 1'b1);
        rdn(gms_pkg::ADDR_COUNT, 2, v);
        chk(v, 32'(n));
        rdn(gms_pkg::ADDR_CHARGE, 4, v);
        chk(v, 32'(-3 * n));
        rdn(gms_pkg::ADDR_CURRENT, 1, v);
        chk(v, 32'hfd);
    endtask
    task automatic t_adjust;
        logic [31:0] v;
        logic [31:0] a;
        logic [31:0] b;
        int p = 0;
        wr(gms_pkg::ADDR_SOC, 8'h40);
        for (int i = 0; i < 3; i++) begin
            #1 p += int'(soc_restart_out === 1'b1);
            @(posedge clk_in);
        end
        chk(p, 1);
        rdn(gms_pkg::ADDR_REST_V, 2, v);
        chk(v, 32'h0e42);
        wr(8'h33, 8'h5a);
        repeat (3) @(posedge clk_in);
        chk(tab_data_out, 8'h5a);
        rdn(gms_pkg::ADDR_CC_ADJ, 2, v);
        chk(v, 32'h1234);
        rdn(gms_pkg::ADDR_VM_ADJ, 2, v);
        chk(v, 32'h0567);
        rdn(gms_pkg::ADDR_CC_ACC, 2, a);
        rdn(gms_pkg::ADDR_VM_ACC, 2, b);
        @(posedge clk_in);
        method_cc_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk(method_cc_out, 1'b1);
        rdn(gms_pkg::ADDR_CC_ACC, 2, v);
        chk(v, 32'(16'(a + 32'h1234)));
        rdn(gms_pkg::ADDR_VM_ACC, 2, v);
        chk(v, 32'(16'(b + 32'h0567)));
        wr(gms_pkg::ADDR_MODE, 8'h02);
        rdn(gms_pkg::ADDR_CC_ACC, 2, v);
        chk(v, 32'h0);
        rdn(gms_pkg::ADDR_VM_ACC, 2, v);
        chk(v, 32'(16'(b + 32'h0567)));
        wr(gms_pkg::ADDR_MODE, 8'h04);
        rdn(gms_pkg::ADDR_VM_ACC, 2, v);
        chk(v, 32'h0);
    endtask
    task automatic t_save;
        logic [31:0] v;
        logic [31:0] k;
        logic [15:0] c;
        wr(gms_pkg::ADDR_MODE, 8'h01);
        repeat (4) @(posedge clk_in);
        chk(method_cc_out, 1'b0);
        chk(mode_sel_out, 1'b1);
        wait_volt;
        c = cur_cyc;
        rdn(gms_pkg::ADDR_COUNT, 2, k);
        wait_volt;
        chk(cur_cyc, c);
        rdn(gms_pkg::ADDR_COUNT, 2, v);
        chk(v, k);
        rdn(gms_pkg::ADDR_VOLTAGE, 2, v);
        chk(v, 32'h0abc);
    endtask

    task automatic stop_test;
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence after reset.
    initial begin
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset;
        t_volt_only;
        t_mixed;
        t_adjust;
        t_save;
        stop_test;
    end
    // Watchdog, well beyond the six or so periods the tests need.
    initial begin
        #200000;
        miscompares++;
        stop_test;
    end
endmodule
